// File: pkg/ops_pkg.sv
/*
 * constants, state and carrier types of the overpower protection sequencer.
 * assumes a 20 mhz core clock and comparator levels from the analog front end.
 */
// Notes on behaviour
// - start overpower timer above 400 mV level
// - trip only after uninterrupted timeout; latched 160 ms
// - trip stops switching; restart or latch off
// - non-latched timeout 27.5 ms, output above half
// - non-latched timeout 14.5 ms when output low
// - level drop clears the timer at once
// - timeout from divided clock, unsynchronised start
// - restart runs three supply cycles before switching
// - at startup threshold discharge again meanwhile
// - restart discharge uses the 2.5 mA sink
// - first restart discharge keeps sink off
// - current sense above 575 mV ends cycle
// - keep switching until trip or undervoltage
// - peak power raises frequency 65 to 130 kHz
// - short protection lowers switching frequency
// - non-latched variant repeats trip and restart
// - short protection only below half trip level
// - short conditions after blanking delay stroke fourfold
package ops_pkg;

    // ----------------------------------------------------------------
    // clock and time figures
    // ----------------------------------------------------------------
    localparam int CLK_KHZ    = 20000;          // core_clk rate
    localparam int CLK_NS     = 50;             // core_clk period
    localparam int TICK_US    = 500;            // divided timer tick
    localparam int TICK_CYC   = TICK_US * CLK_KHZ / 1000;
    localparam int TO_NL_US   = 27500;          // non-latched timeout
    localparam int TO_SH_US   = 14500;          // short-circuit timeout
    localparam int TO_LT_US   = 160000;         // latched timeout
    localparam int BLANK_NS   = 1000;           // short check point
    localparam int F_NOM_KHZ  = 65;
    localparam int F_PK_KHZ   = 130;
    localparam int RST_CYCLES = 3;              // slow restart supply cycles

    // ----------------------------------------------------------------
    // derived counts
    // ----------------------------------------------------------------
    localparam logic [9:0]  TO_NL   = 10'(TO_NL_US / TICK_US);
    localparam logic [9:0]  TO_SH   = 10'(TO_SH_US / TICK_US);
    localparam logic [9:0]  TO_LT   = 10'(TO_LT_US / TICK_US);
    localparam logic [10:0] BLANK   = 11'((BLANK_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [10:0] PER_NOM = 11'(CLK_KHZ / F_NOM_KHZ);
    localparam logic [10:0] PER_PK  = 11'(CLK_KHZ / F_PK_KHZ);
    localparam logic [10:0] PER_STP = 11'h010;  // period step per stroke
    localparam logic [1:0]  RST_LST = 2'(RST_CYCLES - 1);
    localparam int          SHORT_X = 2;        // fourfold delay as shift

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {ST_OFF, ST_RUN, ST_LATCH, ST_DCH, ST_CHG} ops_st_e;

    // comparator levels from the analog front end
    typedef struct packed {
        logic opp_above;       // control level above 400 mV
        logic overcurrent_limit; // current sense above 575 mV
        logic peak_hit;        // current sense above control level
        logic half_low;        // output below half ovp trip level
        logic uvlo;            // supply below undervoltage_threshold
        logic startup;         // supply at startup threshold
        logic latch_sel;       // latched variant strap
    } ops_cmp_s;

    // controls to the power stage and supply
    typedef struct packed {
        logic gate;            // power switch on
        logic sink;            // restart_discharge_current sink on
        logic latched;         // latched-off state
        logic trip;            // overpower trip pulse
        logic short_on;        // output_short_protection delaying strokes
    } ops_out_s;

    localparam ops_out_s OUT_RST = '0;

endpackage

// File: verilog/ops_sync.sv
/*
 * three-stage synchroniser for asynchronous comparator levels.
 * a change passes once the second and third stages agree.
 */
`timescale 1ns/100ps
module ops_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // ----------------------------------------------------------------
    // per-bit agreement filter
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
            end
        end
    endgenerate

    // stage registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r  <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end

    assign q = q_r;

endmodule

// File: verilog/ops_top.sv
/*
 * overpower protection sequencer: overpower timer, latch or slow restart,
 * cycle-by-cycle current limit, peak power and short-circuit stroke timing.
 * assumes comparator levels arrive asynchronously and the supply capacitor
 * is charged by an external start-up circuit.
 */
`timescale 1ns/100ps
module ops_top #(
    parameter int TICK_CYC = ops_pkg::TICK_CYC
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire ops_pkg::ops_cmp_s cmp_raw,
    output ops_pkg::ops_out_s     ctl
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    ops_pkg::ops_cmp_s c;
    ops_pkg::ops_st_e  st_r;
    ops_pkg::ops_st_e  st_nxt;
    ops_pkg::ops_out_s out_r;
    ops_pkg::ops_out_s out_nxt;
    logic [1:0]        rcnt_r;
    logic [1:0]        rcnt_nxt;
    logic [13:0]       tdiv_r;
    logic [13:0]       tdiv_nxt;
    logic [9:0]        otmr_r;
    logic [9:0]        otmr_nxt;
    logic [10:0]       ocnt_r;
    logic [10:0]       ocnt_nxt;
    logic [10:0]       per_r;
    logic [10:0]       per_nxt;
    logic [10:0]       pk_r;
    logic [10:0]       pk_nxt;
    logic [9:0]        tov;
    logic [10:0]       maxon;
    logic              tick;
    logic              run;
    logic              expire;
    logic              wrap;
    logic              at_blank;
    logic              short_hit;

    // ----------------------------------------------------------------
    // comparator synchronisers
    // ----------------------------------------------------------------
    ops_sync #(
        .W ($bits(ops_pkg::ops_cmp_s))
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        (cmp_raw),
        .q        (c)
    );

    assign run = (st_r == ops_pkg::ST_RUN);

    // ----------------------------------------------------------------
    // overpower timer
    // ----------------------------------------------------------------
    // timeout selection per variant and output level
    always_comb begin
        if (c.latch_sel) begin
            tov = ops_pkg::TO_LT;
        end else if (c.half_low) begin
            tov = ops_pkg::TO_SH;
        end else begin
            tov = ops_pkg::TO_NL;
        end
    end

    // free-running divider; the timer start is not aligned to it
    always_comb begin
        tick     = (tdiv_r == 14'(TICK_CYC - 1));
        tdiv_nxt = tick ? 14'h0000 : tdiv_r + 14'h0001;
        expire   = run && c.opp_above && (otmr_r >= tov);
        if (!run || !c.opp_above) begin
            otmr_nxt = 10'h000;
        end else if (tick && !expire) begin
            otmr_nxt = otmr_r + 10'h001;
        end else begin
            otmr_nxt = otmr_r;
        end
    end

    // timer registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tdiv_r <= 14'h0000;
            otmr_r <= 10'h000;
        end else begin
            tdiv_r <= tdiv_nxt;
            otmr_r <= otmr_nxt;
        end
    end

    // ----------------------------------------------------------------
    // stroke oscillator
    // ----------------------------------------------------------------
    // period ramp for peak power, fourfold delay for a shorted output
    always_comb begin
        wrap      = (ocnt_r >= per_r - 11'h001);
        at_blank  = (ocnt_r == ops_pkg::BLANK);
        maxon     = pk_r - (pk_r >> 2);
        short_hit = at_blank && c.half_low && c.opp_above && c.peak_hit;
        ocnt_nxt  = wrap ? 11'h000 : ocnt_r + 11'h001;
        pk_nxt    = pk_r;
        per_nxt   = per_r;
        if (!run) begin
            ocnt_nxt = 11'h000;
            pk_nxt   = ops_pkg::PER_NOM;
            per_nxt  = ops_pkg::PER_NOM;
        end else if (wrap) begin
            if (!c.opp_above) begin
                pk_nxt = ops_pkg::PER_NOM;
            end else if (pk_r >= ops_pkg::PER_PK + ops_pkg::PER_STP) begin
                pk_nxt = pk_r - ops_pkg::PER_STP;
            end else begin
                pk_nxt = ops_pkg::PER_PK;
            end
            per_nxt = pk_nxt;
        end else if (short_hit) begin
            per_nxt = pk_r << ops_pkg::SHORT_X;
        end
    end

    // ----------------------------------------------------------------
    // protection state machine
    // ----------------------------------------------------------------
    // latch, slow restart and stroke gating
    always_comb begin
        st_nxt           = st_r;
        rcnt_nxt         = rcnt_r;
        out_nxt          = out_r;
        out_nxt.trip     = 1'b0;
        out_nxt.latched  = 1'b0;
        out_nxt.gate     = 1'b0;
        case (st_r)
            ops_pkg::ST_OFF: begin
                out_nxt.sink = 1'b0;
                if (c.startup && !c.uvlo) begin
                    st_nxt = ops_pkg::ST_RUN;
                end
            end
            ops_pkg::ST_RUN: begin
                out_nxt.sink = 1'b0;
                if (expire) begin
                    out_nxt.trip = 1'b1;
                    rcnt_nxt     = 2'h0;
                    if (c.latch_sel) begin
                        st_nxt          = ops_pkg::ST_LATCH;
                        out_nxt.latched = 1'b1;
                    end else begin
                        st_nxt = ops_pkg::ST_DCH;
                    end
                end else if (c.uvlo) begin
                    st_nxt = ops_pkg::ST_OFF;
                end else if (wrap) begin
                    out_nxt.gate = 1'b1;
                end else if (c.overcurrent_limit) begin
                    out_nxt.gate = 1'b0;
                end else if (ocnt_r >= ops_pkg::BLANK && c.peak_hit) begin
                    out_nxt.gate = 1'b0;
                end else if (ocnt_r >= maxon) begin
                    out_nxt.gate = 1'b0;
                end else begin
                    out_nxt.gate = out_r.gate;
                end
            end
            ops_pkg::ST_LATCH: begin
                out_nxt.latched = 1'b1;
                if (c.uvlo) begin
                    st_nxt          = ops_pkg::ST_OFF;
                    out_nxt.latched = 1'b0;
                end
            end
            ops_pkg::ST_DCH: begin
                out_nxt.sink = (rcnt_r != 2'h0);
                if (c.uvlo) begin
                    st_nxt       = ops_pkg::ST_CHG;
                    out_nxt.sink = 1'b0;
                end
            end
            ops_pkg::ST_CHG: begin
                out_nxt.sink = 1'b0;
                if (c.startup && !c.uvlo) begin
                    if (rcnt_r == ops_pkg::RST_LST) begin
                        st_nxt   = ops_pkg::ST_RUN;
                        rcnt_nxt = 2'h0;
                    end else begin
                        st_nxt       = ops_pkg::ST_DCH;
                        rcnt_nxt     = rcnt_r + 2'h1;
                        out_nxt.sink = 1'b1;
                    end
                end
            end
            default: begin
                st_nxt  = ops_pkg::ST_OFF;
                out_nxt = ops_pkg::OUT_RST;
            end
        endcase
        if (!run) begin
            out_nxt.short_on = 1'b0;
        end else if (wrap) begin
            out_nxt.short_on = 1'b0;
        end else if (short_hit) begin
            out_nxt.short_on = 1'b1;
        end
    end

    // state registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r   <= ops_pkg::ST_OFF;
            rcnt_r <= 2'h0;
            out_r  <= ops_pkg::OUT_RST;
        end else begin
            st_r   <= st_nxt;
            rcnt_r <= rcnt_nxt;
            out_r  <= out_nxt;
        end
    end

    // oscillator registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ocnt_r <= 11'h000;
            per_r  <= ops_pkg::PER_NOM;
            pk_r   <= ops_pkg::PER_NOM;
        end else begin
            ocnt_r <= ocnt_nxt;
            per_r  <= per_nxt;
            pk_r   <= pk_nxt;
        end
    end

    assign ctl = out_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    property p_tmr_clear;
        !c.opp_above |=> (otmr_r == 10'h000);
    endproperty
    a_tmr_clear: assert property (p_tmr_clear) else $error("timer not cleared");

    property p_tmr_count;
        run && c.opp_above && tick && !expire ##1 run && c.opp_above
            |-> (otmr_r == $past(otmr_r) + 10'h001);
    endproperty
    a_tmr_count: assert property (p_tmr_count) else $error("timer not counting");

    property p_trip_time;
        $rose(out_r.trip) |-> ($past(otmr_r) >= $past(tov)) && $past(c.opp_above);
    endproperty
    a_trip_time: assert property (p_trip_time) else $error("early trip");

    property p_trip_stop;
        out_r.trip |-> !out_r.gate ##1 (st_r != ops_pkg::ST_RUN);
    endproperty
    a_trip_stop: assert property (p_trip_stop) else $error("switching after trip");

    property p_latch_sel;
        $rose(out_r.latched) |-> $past(c.latch_sel) && out_r.trip;
    endproperty
    a_latch_sel: assert property (p_latch_sel) else $error("latch in wrong variant");

    property p_latch_hold;
        out_r.latched && !c.uvlo |=> out_r.latched;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch released early");

    property p_cur_limit;
        run && out_r.gate && c.overcurrent_limit && !wrap |=> !out_r.gate;
    endproperty
    a_cur_limit: assert property (p_cur_limit) else $error("overcurrent did not end stroke");

    property p_first_dch;
        (st_r == ops_pkg::ST_DCH) && (rcnt_r == 2'h0) |-> !out_r.sink;
    endproperty
    a_first_dch: assert property (p_first_dch) else $error("sink on in first discharge");

    property p_later_dch;
        (st_r == ops_pkg::ST_DCH) && (rcnt_r != 2'h0) |-> out_r.sink;
    endproperty
    a_later_dch: assert property (p_later_dch) else $error("sink off in discharge");

    property p_resume;
        (st_r == ops_pkg::ST_CHG) && c.startup && !c.uvlo
            |=> (st_r == (($past(rcnt_r) == ops_pkg::RST_LST) ? ops_pkg::ST_RUN : ops_pkg::ST_DCH));
    endproperty
    a_resume: assert property (p_resume) else $error("restart cycle count wrong");

    property p_short_delay;
        $rose(out_r.short_on) |-> (per_r == (pk_r << ops_pkg::SHORT_X));
    endproperty
    a_short_delay: assert property (p_short_delay) else $error("short delay not fourfold");

    property p_latch_to;
        $rose(out_r.latched) |-> ($past(otmr_r) == ops_pkg::TO_LT);
    endproperty
    a_latch_to: assert property (p_latch_to) else $error("latched timeout length wrong");

    property p_trip_dch;
        $rose(out_r.trip) && !out_r.latched |-> (st_r == ops_pkg::ST_DCH) && (rcnt_r == 2'h0);
    endproperty
    a_trip_dch: assert property (p_trip_dch) else $error("no restart after trip");

    property p_chg_dch;
        (st_r == ops_pkg::ST_CHG) && c.startup && !c.uvlo && (rcnt_r != ops_pkg::RST_LST) |=> out_r.sink;
    endproperty
    a_chg_dch: assert property (p_chg_dch) else $error("no discharge at startup level");

    property p_gate_run;
        out_r.gate |-> run;
    endproperty
    a_gate_run: assert property (p_gate_run) else $error("switching outside run state");

    property p_short_half;
        $rose(out_r.short_on) |-> $past(c.half_low) && $past(c.opp_above) && $past(c.peak_hit);
    endproperty
    a_short_half: assert property (p_short_half) else $error("short protection without low output");

    property p_pk_step;
        run && wrap && c.opp_above && (pk_r >= ops_pkg::PER_PK + ops_pkg::PER_STP)
            |=> (pk_r == $past(pk_r) - ops_pkg::PER_STP);
    endproperty
    a_pk_step: assert property (p_pk_step) else $error("peak period did not step");

    property p_pk_range;
        run |-> (pk_r >= ops_pkg::PER_PK) && (pk_r <= ops_pkg::PER_NOM);
    endproperty
    a_pk_range: assert property (p_pk_range) else $error("base period out of range");

    c_trip:    cover property ($rose(out_r.trip));
    c_latch:   cover property ($rose(out_r.latched));
    c_restart: cover property ((st_r == ops_pkg::ST_CHG) ##1 run);
    c_short:   cover property ($rose(out_r.short_on));

endmodule

// File: tb/ops_supply_model.sv
/*
 * behavioural supply capacitor, start-up circuit and auxiliary winding.
 * assumes one core_clk domain; supply voltage is a scaled integer count.
 */
`timescale 1ns/100ps
module ops_supply_model #(
    parameter int UV   = 200,
    parameter int ST   = 1600,
    parameter int HOLD = 1500
) (
    input  wire logic              core_clk,
    input  wire ops_pkg::ops_out_s ctl,
    output logic                   uvlo,
    output logic                   startup
);
    // ------------------------------------------------------------
    // supply charge balance
    // ------------------------------------------------------------
    int   vcc_r  = 0;
    logic pd_r   = 1'b1;
    logic gate_r = 1'b0;

    // power-down charges from the start-up circuit, otherwise the chip drains it
    always @(posedge core_clk) begin
        gate_r <= ctl.gate;
        if (pd_r) begin
            vcc_r <= vcc_r + 2;
            pd_r  <= (vcc_r < ST);
        end else if (vcc_r < UV) begin
            pd_r <= 1'b1;
        end else if (ctl.gate && !gate_r) begin
            vcc_r <= HOLD;              // auxiliary winding refills on each stroke
        end else if (ctl.sink) begin
            vcc_r <= vcc_r - 4;         // restart sink, about four times supply current
        end else begin
            vcc_r <= vcc_r - 1;         // operating supply current alone
        end
    end

    // small bands so each level lasts long enough for the synchroniser
    assign uvlo    = (vcc_r < UV + 32);
    assign startup = (vcc_r >= ST - 64);
endmodule

// File: tb/tb.sv
/*
 * self-checking bench for the overpower protection sequencer.
 * assumes the supply model drives the undervoltage and startup levels.
 */
`timescale 1ns/100ps
module tb;
    // ------------------------------------------------------------
    // clock, design and supply model
    // ------------------------------------------------------------
    localparam int TICK = 40;          // shortened timer tick

    logic              core_clk  = 1'b0;
    logic              rst_n     = 1'b0;
    ops_pkg::ops_cmp_s cmp_tb    = '0;
    ops_pkg::ops_cmp_s cmp_raw;
    ops_pkg::ops_out_s ctl;
    ops_pkg::ops_out_s ctl_s     = '0;
    logic              uvlo;
    logic              startup;
    logic              uvlo_q    = 1'b0;
    int                bad_count = 0;
    int                tests_run = 0;
    int                seed      = 37223;
    int                cyc       = 0;
    int                last_rise = 0;
    int                period    = 0;
    int                ev[7]     = '{default: 0};  // trip, gate up, short up, latch down, gate down, uvlo up, sink up

    always #25 core_clk = ~core_clk;

    assign cmp_raw = {cmp_tb[6:3], uvlo, startup, cmp_tb[0]};

    ops_top #(
        .TICK_CYC (TICK)
    ) ops_top_inst (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .cmp_raw  (cmp_raw),
        .ctl      (ctl)
    );

    ops_supply_model ops_supply_model_inst (
        .core_clk (core_clk),
        .ctl      (ctl),
        .uvlo     (uvlo),
        .startup  (startup)
    );

    // event counters, sampled where outputs are settled
    always @(negedge core_clk) begin
        cyc = cyc + 1;
        if (ctl.trip) ev[0]++;
        if (ctl.gate && !ctl_s.gate) begin
            ev[1]++;
            period    = cyc - last_rise;
            last_rise = cyc;
        end
        if (ctl.short_on && !ctl_s.short_on) ev[2]++;
        if (ctl_s.latched && !ctl.latched) ev[3]++;
        if (ctl_s.gate && !ctl.gate) ev[4]++;
        if (uvlo && !uvlo_q) ev[5]++;
        if (ctl.sink && !ctl_s.sink) ev[6]++;
        uvlo_q = uvlo;
        ctl_s  = ctl;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic set_in(input logic opp, input logic lim, input logic pk, input logic half);
        @(posedge core_clk);
        cmp_tb <= {opp, lim, pk, half, 2'h0, cmp_tb[0]};
    endtask

    task automatic do_reset(input logic latch);
        @(posedge core_clk);
        rst_n  <= 1'b0;
        cmp_tb <= {6'h00, latch};
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
    endtask

    // waits for counter k to move, at most lim cycles
    task automatic wait_ev(input int k, input int lim, output int n);
        int c0;
        c0 = ev[k];
        n  = 0;
        while (ev[k] == c0 && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        check("event arrives in time", n < lim, 1'b1);
    endtask

    // expected overpower timeout in cycles
    function automatic int exp_to(input logic latch, input logic half);
        if (latch) return 160000 / ops_pkg::TICK_US * TICK;
        if (half) return 14500 / ops_pkg::TICK_US * TICK;
        return 27500 / ops_pkg::TICK_US * TICK;
    endfunction

    // unaligned tick start allows one tick either way
    task automatic chk_to(input int n, input int exp);
        check("trip delay in window", (n >= exp - TICK) && (n <= exp + TICK), 1'b1);
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (100000) @(posedge core_clk);
        bad_count++;
        end_of_test();
    end

    initial begin
        int n;
        int t0;
        int g0;
        int s0;
        int u0;
        int p1;
        do_reset(1'b0);
        wait_ev(1, 3000, n);
        $display("test power-up finished");
        // peak power shortens the period stroke by stroke
        set_in(1'b1, 1'b0, 1'b0, 1'b0);
        wait_ev(1, 400, n);
        p1 = period;
        wait_ev(1, 400, n);
        check("peak period bound", p1 <= 20000 / 65, 1'b1);
        check("peak period drops", period < p1, 1'b1);
        set_in(1'b0, 1'b0, 1'b0, 1'b0);
        cycles(20);
        $display("test peak power finished");
        // random brief overloads never reach the timeout
        for (int i = 0; i < 4; i++) begin
            set_in(1'b1, 1'b0, 1'($random(seed)), 1'b0);
            cycles(300 + ($random(seed) & 32'h3ff));
            set_in(1'b0, 1'b0, 1'b0, 1'b0);
            cycles(12);
        end
        // corner: overload ends just short of the timeout
        set_in(1'b1, 1'b0, 1'b0, 1'b0);
        cycles(exp_to(1'b0, 1'b0) - 2 * TICK - 10);
        set_in(1'b0, 1'b0, 1'b0, 1'b0);
        cycles(12);
        check("trips after brief overloads", ev[0], 0);
        check("short with output high", ev[2], 0);
        $display("test brief overload finished");
        // current limit cuts the stroke but switching goes on
        wait_ev(1, 400, n);
        cycles(30);
        set_in(1'b0, 1'b1, 1'b0, 1'b0);
        wait_ev(4, 12, n);
        g0 = ev[1];
        cycles(1000);
        check("strokes under current limit", ev[1] - g0 >= 3, 1'b1);
        set_in(1'b0, 1'b0, 1'b0, 1'b0);
        $display("test overcurrent finished");
        // restart variant: trip, three supply cycles, repeat
        cycles(20);
        set_in(1'b1, 1'b0, 1'b0, 1'b0);
        t0 = cyc;
        wait_ev(0, 2600, n);
        chk_to(cyc - t0, exp_to(1'b0, 1'b0));
        s0 = ev[6];
        u0 = ev[5];
        cycles(3);
        check("gate after trip", ctl_s.gate, 1'b0);
        wait_ev(5, 2000, n);
        check("sink in first discharge", ev[6] - s0, 0);
        wait_ev(1, 6000, n);
        check("restart sink discharges", ev[6] - s0, 2);
        check("restart supply cycles", ev[5] - u0, 3);
        wait_ev(0, 6000, n);
        check("repeated trip", ev[0], 2);
        set_in(1'b0, 1'b0, 1'b0, 1'b0);
        wait_ev(1, 6000, n);
        $display("test slow restart finished");
        // output short: delayed strokes and shorter timeout
        cycles(20);
        set_in(1'b1, 1'b0, 1'b1, 1'b1);
        t0 = cyc;
        wait_ev(2, 700, n);
        g0 = ev[1];
        cycles(560);
        check("stroke delayed under short", ev[1] - g0, 0);
        wait_ev(0, 1400, n);
        chk_to(cyc - t0, exp_to(1'b0, 1'b1));
        set_in(1'b0, 1'b0, 1'b0, 1'b0);
        $display("test output short finished");
        // latched variant ignores the low output and holds until undervoltage
        do_reset(1'b1);
        wait_ev(1, 6000, n);
        set_in(1'b1, 1'b0, 1'b0, 1'b1);
        t0 = cyc;
        wait_ev(0, 13500, n);
        chk_to(cyc - t0, exp_to(1'b1, 1'b1));
        u0 = ev[5];
        cycles(3);
        check("latched after trip", ctl_s.latched, 1'b1);
        wait_ev(3, 3000, n);
        check("latch held until undervoltage", ev[5] - u0, 1);
        $display("test latched finished");
        end_of_test();
    end
endmodule
